/* rtl/rhp_pkg.sv */
// constants for the root hub port attribute and global status registers
//
// Functional notes
// R1: attributes at 4Ch, global status at 50h
// R2: upper half masks port power per port
// R3: unmasked ports follow global power commands
// R4: global switching mode ignores the mask
// R5: mask bit 0 reserved, bits map ports
// R6: lower half: set means device not removable
// R7: removable bit 0 reserved, bits map ports
// R8: software programs both fields at initialization
// R9: reset pattern is implementation chosen
// R10: status low half, change bits high half
// R11: software writes zero to reserved bits
// R12: bit 16 powers on, bit 0 off
// R13: bit 15 sets wake, bit 31 clears
// R14: bit 1 overcurrent, bit 17 change flag
// R15: unimplemented port bits stay zero
package rhp_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] RHP_ATTR_OFS = 8'h4C;
  localparam logic [7:0] RHP_STAT_OFS = 8'h50;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RHP_MASK_LSB    = 16;
  localparam int RHP_PWR_OFF_BIT = 0;
  localparam int RHP_OCI_BIT     = 1;
  localparam int RHP_WAKE_BIT    = 15;
  localparam int RHP_PWR_ON_BIT  = 16;
  localparam int RHP_OCC_BIT     = 17;
  localparam int RHP_WCLR_BIT    = 31;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RHP_MASK_RST  = 16'h0002;
  localparam logic [15:0] RHP_FIXED_RST = 16'h0000;
  localparam logic [15:0] RHP_ZERO16    = 16'h0000;
  localparam logic [31:0] RHP_ZERO32    = 32'h0000_0000;
endpackage

/* rtl/rhp_regs.sv */
// root hub port attribute and global status register logic
`timescale 1ns/100ps
`default_nettype none
module rhp_regs
  import rhp_pkg::*;
#(
  parameter int NUM_PORTS = 2
)
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // register access
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [31:0] reg_wdata_in,
  output logic      [31:0] reg_rdata_out,
  // root hub configuration
  input  wire logic        power_switching_select_in,
  input  wire logic        per_port_oc_in,
  input  wire logic        global_oc_in,
  // per-port power commands, bit n is port n
  input  wire logic [15:0] port_pwr_set_in,
  input  wire logic [15:0] port_pwr_clr_in,
  // connect change while suspended
  input  wire logic        connect_change_in,
  input  wire logic        suspended_in,
  // outputs
  output logic      [15:0] port_power_out,
  output logic      [15:0] device_fixed_map_out,
  output logic             remote_wake_enable_out,
  output logic             resume_event_out
);
  // ---------------------------------------------------------------
  // implemented port bits
  // ---------------------------------------------------------------
  function automatic logic [15:0] port_bits();
    logic [15:0] m;
    m = RHP_ZERO16;
    for (int i = 1; i <= NUM_PORTS && i < 16; i++)
    begin
      m[i] = 1'b1;
    end
    return m;
  endfunction

  localparam logic [15:0] PORT_MASK = port_bits();

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] port_power_ctrl_mask_q;
  logic [15:0] port_power_ctrl_mask_d;

  logic [15:0] device_fixed_map_q;
  logic [15:0] device_fixed_map_d;

  logic        remote_wake_enable_q;
  logic        remote_wake_enable_d;

  logic        oci_q;
  logic        oci_d;

  logic        overcurrent_change_flag_q;
  logic        overcurrent_change_flag_d;

  logic [15:0] port_power_q;
  logic [15:0] port_power_d;

  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  logic        resume_q;
  logic        resume_d;

  // ---------------------------------------------------------------
  // decode and steering signals
  // ---------------------------------------------------------------
  logic        wr_attr;
  logic        wr_stat;
  logic        rd_attr;
  logic        rd_stat;
  logic        global_power_on_cmd;
  logic        global_power_off_cmd;
  logic        wake_enable_set;
  logic        wake_enable_clear;
  logic        change_flag_clear;
  logic [15:0] global_ports;
  logic [15:0] masked_ports;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  assign wr_attr = reg_hit(reg_wr_in, reg_addr_in, RHP_ATTR_OFS); // R1
  assign wr_stat = reg_hit(reg_wr_in, reg_addr_in, RHP_STAT_OFS); // R1
  assign rd_attr = reg_hit(reg_rd_in, reg_addr_in, RHP_ATTR_OFS); // R1
  assign rd_stat = reg_hit(reg_rd_in, reg_addr_in, RHP_STAT_OFS); // R1

  // ---------------------------------------------------------------
  // status register write commands
  // ---------------------------------------------------------------
  assign global_power_on_cmd  = wr_stat && reg_wdata_in[RHP_PWR_ON_BIT];
  assign global_power_off_cmd = wr_stat && reg_wdata_in[RHP_PWR_OFF_BIT];
  assign wake_enable_set      = wr_stat && reg_wdata_in[RHP_WAKE_BIT];
  assign wake_enable_clear    = wr_stat && reg_wdata_in[RHP_WCLR_BIT];
  assign change_flag_clear    = wr_stat && reg_wdata_in[RHP_OCC_BIT];

  // ---------------------------------------------------------------
  // port attributes, reserved bit 0 and absent ports held zero
  // ---------------------------------------------------------------
  always_comb
  begin
    port_power_ctrl_mask_d = port_power_ctrl_mask_q;
    device_fixed_map_d     = device_fixed_map_q;
    if (wr_attr)
    begin
      port_power_ctrl_mask_d = reg_wdata_in[RHP_MASK_LSB +: 16]
                             & PORT_MASK; // R2 R5 R15
      device_fixed_map_d     = reg_wdata_in[15:0] & PORT_MASK; // R6 R7 R15
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      port_power_ctrl_mask_q <= RHP_MASK_RST;  // R9
      device_fixed_map_q     <= RHP_FIXED_RST; // R9
    end
    else
    begin
      port_power_ctrl_mask_q <= port_power_ctrl_mask_d;
      device_fixed_map_q     <= device_fixed_map_d;
    end
  end

  // ---------------------------------------------------------------
  // remote wake-up enable, clear wins over set
  // ---------------------------------------------------------------
  always_comb
  begin
    remote_wake_enable_d = remote_wake_enable_q;
    if (wake_enable_set)
    begin
      remote_wake_enable_d = 1'b1; // R13
    end
    if (wake_enable_clear)
    begin
      remote_wake_enable_d = 1'b0; // R13
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      remote_wake_enable_q <= 1'b0;
    end
    else
    begin
      remote_wake_enable_q <= remote_wake_enable_d;
    end
  end

  // ---------------------------------------------------------------
  // overcurrent indicator and change flag, hardware set wins
  // ---------------------------------------------------------------
  always_comb
  begin
    oci_d                     = global_oc_in && !per_port_oc_in; // R14
    overcurrent_change_flag_d = overcurrent_change_flag_q;
    if (change_flag_clear)
    begin
      overcurrent_change_flag_d = 1'b0; // R14
    end
    if (oci_d != oci_q)
    begin
      overcurrent_change_flag_d = 1'b1; // R14
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oci_q                     <= 1'b0;
      overcurrent_change_flag_q <= 1'b0;
    end
    else
    begin
      oci_q                     <= oci_d;
      overcurrent_change_flag_q <= overcurrent_change_flag_d;
    end
  end

  // ---------------------------------------------------------------
  // port power switching
  // ---------------------------------------------------------------
  always_comb
  begin
    // per-port mode leaves masked ports to per-port commands
    if (power_switching_select_in)
    begin
      masked_ports = port_power_ctrl_mask_q; // R2
    end
    else
    begin
      masked_ports = RHP_ZERO16; // R4
    end
    global_ports = PORT_MASK & ~masked_ports; // R3 R4
    port_power_d = port_power_q;
    if (global_power_on_cmd)
    begin
      port_power_d = port_power_d | global_ports; // R12 R3
    end
    if (global_power_off_cmd)
    begin
      port_power_d = port_power_d & ~global_ports; // R12 R3
    end
    // per-port commands reach masked ports only
    port_power_d = port_power_d | (port_pwr_set_in & masked_ports); // R2
    port_power_d = port_power_d & ~(port_pwr_clr_in & masked_ports); // R2
    port_power_d = port_power_d & PORT_MASK; // R15
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      port_power_q <= RHP_ZERO16;
    end
    else
    begin
      port_power_q <= port_power_d;
    end
  end

  // ---------------------------------------------------------------
  // resume event from a connect change while suspended
  // ---------------------------------------------------------------
  always_comb
  begin
    resume_d = remote_wake_enable_q && suspended_in
             && connect_change_in; // R13
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      resume_q <= 1'b0;
    end
    else
    begin
      resume_q <= resume_d;
    end
  end

  // ---------------------------------------------------------------
  // read data, command bits 0 and 16 read zero
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata_d = RHP_ZERO32;
    if (rd_attr)
    begin
      rdata_d = {port_power_ctrl_mask_q, device_fixed_map_q}; // R2 R6
    end
    else if (rd_stat)
    begin
      rdata_d[RHP_OCI_BIT]  = oci_q;                     // R10 R14
      rdata_d[RHP_WAKE_BIT] = remote_wake_enable_q;      // R10 R13
      rdata_d[RHP_OCC_BIT]  = overcurrent_change_flag_q; // R10 R14
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_q <= RHP_ZERO32;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out          = rdata_q;
  assign port_power_out         = port_power_q;
  assign device_fixed_map_out   = device_fixed_map_q;
  assign remote_wake_enable_out = remote_wake_enable_q;
  assign resume_event_out       = resume_q;
endmodule
`default_nettype wire

/* verification/rhp_regs_asserts.sv */
// checker for the root hub register block
`timescale 1ns/100ps
`default_nettype none
module rhp_regs_chk
  import rhp_pkg::*;
#(parameter int NUM_PORTS = 2)
(
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [15:0] port_power_out,
  input wire logic [15:0] device_fixed_map_out,
  input wire logic        remote_wake_enable_out,
  input wire logic        power_switching_select_in
);
  localparam logic [15:0] VM = 16'((1 << (NUM_PORTS + 1)) - 2);
  wire logic              ws = reg_wr_in && reg_addr_in == RHP_STAT_OFS;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // register properties
  // ------------------------------------------------------------
  sequence s_rd(logic [7:0] a); reg_rd_in && reg_addr_in == a; endsequence
  property p_idle; !reg_rd_in |=> reg_rdata_out == RHP_ZERO32; endproperty
  a_idle: assert property (p_idle) else $error("stale read data");
  property p_unmap; reg_rd_in && reg_addr_in != RHP_ATTR_OFS &&
    reg_addr_in != RHP_STAT_OFS |=> reg_rdata_out == RHP_ZERO32; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_stat; s_rd(RHP_STAT_OFS) |=>
    (reg_rdata_out & 32'hFFFD_7FFD) == RHP_ZERO32; endproperty
  a_stat: assert property (p_stat) else $error("status layout");
  property p_attr; s_rd(RHP_ATTR_OFS) |=>
    (reg_rdata_out & ~{VM, VM}) == RHP_ZERO32; endproperty
  a_attr: assert property (p_attr) else $error("attribute bits");
  property p_map; reg_wr_in && reg_addr_in == RHP_ATTR_OFS |=>
    device_fixed_map_out == ($past(reg_wdata_in[15:0]) & VM); endproperty
  a_map: assert property (p_map) else $error("removable map");
  property p_wset; ws && reg_wdata_in[15] && !reg_wdata_in[31] |=>
    remote_wake_enable_out; endproperty
  a_wset: assert property (p_wset) else $error("wake set");
  property p_wclr; ws && reg_wdata_in[31] |=> !remote_wake_enable_out;
  endproperty
  a_wclr: assert property (p_wclr) else $error("wake clear");
  property p_pp; (port_power_out & ~VM) == RHP_ZERO16; endproperty
  a_pp: assert property (p_pp) else $error("power on absent port");
  property p_gon; ws && reg_wdata_in[16] && !reg_wdata_in[0] &&
    !power_switching_select_in |=> port_power_out == VM; endproperty
  a_gon: assert property (p_gon) else $error("global power on");
endmodule
bind rhp_regs rhp_regs_chk #(.NUM_PORTS(NUM_PORTS)) i_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .port_power_out(port_power_out),
  .device_fixed_map_out(device_fixed_map_out),
  .remote_wake_enable_out(remote_wake_enable_out),
  .power_switching_select_in(power_switching_select_in));
`default_nettype wire

/* verification/rhp_regs_tb_top.sv */
// self-checking bench for the root hub register block
`timescale 1ns/100ps
`default_nettype none
module rhp_regs_tb_top;
  import rhp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_p = 1'b0;
  logic        pss = 1'b0, goc = 1'b0, cc = 1'b0, sus = 1'b0, wk, res;
  logic        ppo = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [15:0] ps = 16'h0000, pc = 16'h0000, pp, map;
  logic [31:0] wd = 32'h0000_0000, rdat, seed = 32'h0001_1A41;
  logic [31:0] q[$];
  int          failures = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  rhp_regs #(.NUM_PORTS(2)) i_dut (.core_clk_in(clk), .rst_in(rst),
    .reg_addr_in(adr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .power_switching_select_in(pss),
    .per_port_oc_in(ppo), .global_oc_in(goc), .port_pwr_set_in(ps),
    .port_pwr_clr_in(pc), .connect_change_in(cc), .suspended_in(sus),
    .port_power_out(pp), .device_fixed_map_out(map),
    .remote_wake_enable_out(wk), .resume_event_out(res));
  // ------------------------------------------------------------
  // tasks and result monitor
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask
  task automatic pcmd(input logic [15:0] s, c, input logic [31:0] e);
    @(posedge clk);
    ps <= s;
    pc <= c;
    @(posedge clk);
    ps <= 16'h0000;
    pc <= 16'h0000;
    #1;
    chk("port power", 32'(pp), e);
  endtask
  always @(posedge clk)
  begin
    if (rd_p && q.size() > 0)
      chk("read data", rdat, q.pop_front());
    rd_p <= rd;
  end
  initial
  begin
    #100000;
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rreg(RHP_ATTR_OFS, 32'h0002_0000);
    rreg(8'h54, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      wreg(RHP_ATTR_OFS, seed);
      chk("map", 32'(map), seed & 32'h0000_0006);
      rreg(RHP_ATTR_OFS, seed & 32'h0006_0006);
    end
    wreg(RHP_ATTR_OFS, 32'h0002_0000);
    wreg(RHP_STAT_OFS, 32'h0001_0000);
    chk("port power", 32'(pp), 32'h0000_0006);
    rreg(RHP_STAT_OFS, 32'h0000_0000);
    wreg(RHP_STAT_OFS, 32'h0000_0001);
    chk("port power", 32'(pp), 32'h0000_0000);
    @(posedge clk);
    pss <= 1'b1;
    wreg(RHP_STAT_OFS, 32'h0001_0000);
    chk("port power", 32'(pp), 32'h0000_0004);
    pcmd(16'hFFFF, 16'h0000, 32'h0000_0006);
    pcmd(16'h0000, 16'hFFFF, 32'h0000_0004);
    wreg(RHP_STAT_OFS, 32'h0000_0001);
    chk("port power", 32'(pp), 32'h0000_0000);
    wreg(RHP_STAT_OFS, 32'h0000_8000);
    rreg(RHP_STAT_OFS, 32'h0000_8000);
    @(posedge clk);
    sus <= 1'b1;
    cc <= 1'b1;
    @(posedge clk);
    cc <= 1'b0;
    #1;
    chk("resume", 32'(res), 32'h0000_0001);
    wreg(RHP_STAT_OFS, 32'h8000_8000);
    chk("wake", 32'(wk), 32'h0000_0000);
    @(posedge clk);
    goc <= 1'b1;
    repeat (3) @(posedge clk);
    rreg(RHP_STAT_OFS, 32'h0002_0002);
    wreg(RHP_STAT_OFS, 32'h0002_0000);
    rreg(RHP_STAT_OFS, 32'h0000_0002);
    @(posedge clk);
    ppo <= 1'b1;
    repeat (2) @(posedge clk);
    rreg(RHP_STAT_OFS, 32'h0002_0000);
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
